// >>> core/cpu_ctrl.sv
// bus cycle, bus handover, interrupt and reset control of the processor
//
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/10ps
`default_nettype none

module cpu_ctrl (
    // clock, reset, enable
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clkEn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output var logic [31:0] prdata,
    output var logic pready,
    output var logic pslverr,
    // external pins in
    input wire logic ready,
    input wire logic busRequest,
    input wire logic generalIrq,
    input wire logic restart55,
    input wire logic restart65,
    input wire logic restart75,
    input wire logic trapIrq,
    // external pins out
    output var cpu_ctrl_pkg::busPins_t busPins,
    // execution unit side
    input wire cpu_ctrl_pkg::busReq_t cycleReq,
    input wire logic nextToLast,
    input wire logic halted,
    output var logic cycleDone,
    output var logic waitState,
    output var logic resetActive,
    output var cpu_ctrl_pkg::irqOut_t irqOut
);

    typedef struct packed {
        logic [cpu_ctrl_pkg::PIN_COUNT-1:0] syncA;
        logic [cpu_ctrl_pkg::PIN_COUNT-1:0] syncB;
        logic [cpu_ctrl_pkg::PIN_COUNT-1:0] prevB;
        cpu_ctrl_pkg::phase_t phase;
        cpu_ctrl_pkg::kind_t kind;
        logic intackPending;
        logic intackCycle;
        logic ie;
        logic [2:0] mask;
        logic r75Latch;
        logic trapLatch;
        cpu_ctrl_pkg::busPins_t bus;
        cpu_ctrl_pkg::irqOut_t irq;
        logic cycleDone;
        logic waitState;
        logic resetActive;
        logic [7:0] lastVector;
        cpu_ctrl_pkg::src_t lastSrc;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } ctrl_state_t;

    ctrl_state_t s;
    ctrl_state_t next_s;

    logic [cpu_ctrl_pkg::PIN_COUNT-1:0] pinsIn;
    logic readySync;
    logic holdSync;
    logic samplePoint;
    logic trapOk;
    logic ok75;
    logic ok65;
    logic ok55;
    logic okIntr;
    logic edge75;
    logic edgeTrap;
    logic mapped;
    logic apbWrite;
    logic [31:0] readValue;

    assign pinsIn = {trapIrq, restart75, restart65, restart55, generalIrq, busRequest, ready};

    assign readySync = s.syncB[cpu_ctrl_pkg::PIN_READY];
    assign holdSync = s.syncB[cpu_ctrl_pkg::PIN_HOLD];
    assign edge75 = s.syncB[cpu_ctrl_pkg::PIN_R75] & ~s.prevB[cpu_ctrl_pkg::PIN_R75];
    assign edgeTrap = s.syncB[cpu_ctrl_pkg::PIN_TRAP] & ~s.prevB[cpu_ctrl_pkg::PIN_TRAP];

    // requests are looked at only here: next-to-last cycle, bus grant (mid-instruction too) or halt
    assign samplePoint = nextToLast | s.bus.grant | halted;

    // trap needs both its latched edge and a level still high
    assign trapOk = s.trapLatch & s.syncB[cpu_ctrl_pkg::PIN_TRAP];
    assign ok75 = s.r75Latch & ~s.mask[2] & s.ie;
    assign ok65 = s.syncB[cpu_ctrl_pkg::PIN_R65] & ~s.mask[1] & s.ie;
    assign ok55 = s.syncB[cpu_ctrl_pkg::PIN_R55] & ~s.mask[0] & s.ie;
    assign okIntr = s.syncB[cpu_ctrl_pkg::PIN_GENERAL_IRQ] & s.ie;

    assign mapped = (paddr == cpu_ctrl_pkg::OFS_CTRL) || (paddr == cpu_ctrl_pkg::OFS_MASK)
        || (paddr == cpu_ctrl_pkg::OFS_STATUS) || (paddr == cpu_ctrl_pkg::OFS_VECTOR);
    assign apbWrite = psel & penable & s.pready & pwrite & ~s.pslverr;

    always_comb begin
        readValue = 32'h0000_0000;
        case (paddr)
            cpu_ctrl_pkg::OFS_CTRL: begin
                readValue[cpu_ctrl_pkg::IE_BIT] = s.ie;
            end
            cpu_ctrl_pkg::OFS_MASK: begin
                readValue[cpu_ctrl_pkg::MASK_LSB +: 3] = s.mask;
            end
            cpu_ctrl_pkg::OFS_STATUS: begin
                readValue[cpu_ctrl_pkg::ST_PEND_LSB +: 5] = {s.trapLatch, s.r75Latch,
                    s.syncB[cpu_ctrl_pkg::PIN_R65], s.syncB[cpu_ctrl_pkg::PIN_R55],
                    s.syncB[cpu_ctrl_pkg::PIN_GENERAL_IRQ]};
                readValue[cpu_ctrl_pkg::ST_IE_BIT] = s.ie;
                readValue[cpu_ctrl_pkg::ST_GRANT_BIT] = s.bus.grant;
                readValue[cpu_ctrl_pkg::ST_WAIT_BIT] = s.waitState;
                readValue[cpu_ctrl_pkg::ST_ACKPEND_BIT] = s.intackPending;
            end
            cpu_ctrl_pkg::OFS_VECTOR: begin
                readValue[cpu_ctrl_pkg::VEC_LSB +: 8] = s.lastVector;
                readValue[cpu_ctrl_pkg::SRC_LSB +: 3] = s.lastSrc;
            end
            default: begin
                readValue = 32'h0000_0000;
            end
        endcase
    end

    always_comb begin
        next_s = s;
        if (clkEn) begin
            // first stage feeds only the second stage
            next_s.syncA = pinsIn;
            next_s.syncB = s.syncA;
            next_s.prevB = s.syncB;
            next_s.irq.take = 1'b0;
            next_s.irq.pushPc = 1'b0;
            next_s.irq.pcIncInhibit = 1'b0;
            next_s.irq.internalRestart = 1'b0;
            next_s.cycleDone = 1'b0;
            next_s.resetActive = 1'b0;
            // the bus is driven again once reset has been let go
            if (s.resetActive) begin
                next_s.bus.driveEn = 1'b1;
            end

            // apb: data captured in setup, answered in first access cycle
            next_s.pready = psel & ~penable;
            next_s.pslverr = 1'b0;
            if (psel & ~penable) begin
                next_s.prdata = readValue;
                next_s.pslverr = ~mapped;
            end
            if (apbWrite && paddr == cpu_ctrl_pkg::OFS_CTRL) begin
                next_s.ie = pwdata[cpu_ctrl_pkg::IE_BIT];
            end
            if (apbWrite && paddr == cpu_ctrl_pkg::OFS_MASK) begin
                if (pwdata[cpu_ctrl_pkg::MASK_SET_BIT]) begin
                    next_s.mask = pwdata[cpu_ctrl_pkg::MASK_LSB +: 3];
                end
                if (pwdata[cpu_ctrl_pkg::R75_CLR_BIT]) begin
                    next_s.r75Latch = 1'b0;
                end
            end

            // bus cycle sequencer
            case (s.phase)
                cpu_ctrl_pkg::PH_IDLE: begin
                    if (holdSync) begin
                        next_s.phase = cpu_ctrl_pkg::PH_GRANT;
                        next_s.bus.grant = 1'b1;
                    end else if (cycleReq.start) begin
                        next_s.phase = cpu_ctrl_pkg::PH_T1;
                        next_s.kind = cycleReq.kind;
                        next_s.intackCycle = s.intackPending
                            && cycleReq.kind == cpu_ctrl_pkg::KIND_FETCH;
                    end
                end
                cpu_ctrl_pkg::PH_T1: begin
                    next_s.phase = cpu_ctrl_pkg::PH_T2;
                    // the source answers with its instruction under this strobe
                    next_s.bus.irqAckStrobe = s.intackCycle;
                    next_s.bus.readStrobe = s.kind != cpu_ctrl_pkg::KIND_WRITE
                        && !s.intackCycle;
                    next_s.bus.writeStrobe = s.kind == cpu_ctrl_pkg::KIND_WRITE;
                end
                cpu_ctrl_pkg::PH_T2, cpu_ctrl_pkg::PH_TW: begin
                    if (readySync) begin
                        next_s.phase = cpu_ctrl_pkg::PH_T3;
                        next_s.waitState = 1'b0;
                    end else begin
                        next_s.phase = cpu_ctrl_pkg::PH_TW;
                        next_s.waitState = 1'b1;
                    end
                end
                cpu_ctrl_pkg::PH_T3: begin
                    next_s.bus.readStrobe = 1'b0;
                    next_s.bus.writeStrobe = 1'b0;
                    next_s.bus.irqAckStrobe = 1'b0;
                    next_s.cycleDone = 1'b1;
                    if (s.intackCycle) begin
                        next_s.intackPending = 1'b0;
                        next_s.intackCycle = 1'b0;
                    end
                    // a pending request takes the bus as soon as this transfer ends
                    if (holdSync) begin
                        next_s.phase = cpu_ctrl_pkg::PH_GRANT;
                        next_s.bus.grant = 1'b1;
                    end else begin
                        next_s.phase = cpu_ctrl_pkg::PH_IDLE;
                    end
                end
                cpu_ctrl_pkg::PH_GRANT: begin
                    // execution keeps running; only new bus cycles wait in idle
                    next_s.bus.driveEn = 1'b0;
                    if (!holdSync) begin
                        next_s.bus.grant = 1'b0;
                        next_s.phase = cpu_ctrl_pkg::PH_REGAIN;
                    end
                end
                cpu_ctrl_pkg::PH_REGAIN: begin
                    // half a processor cycle rounds up to one clock here
                    next_s.bus.driveEn = 1'b1;
                    next_s.phase = cpu_ctrl_pkg::PH_IDLE;
                end
                default: begin
                    next_s.phase = cpu_ctrl_pkg::PH_IDLE;
                end
            endcase

            // one source per sample point, highest first
            if (samplePoint) begin
                if (trapOk) begin
                    next_s.irq.take = 1'b1;
                    next_s.irq.vector = cpu_ctrl_pkg::VEC_TRAP;
                    next_s.irq.pushPc = 1'b1;
                    next_s.irq.internalRestart = 1'b1;
                    next_s.trapLatch = 1'b0;
                    next_s.ie = 1'b0;
                    next_s.lastSrc = cpu_ctrl_pkg::SRC_TRAP;
                end else if (ok75 || ok65 || ok55) begin
                    next_s.irq.take = 1'b1;
                    next_s.irq.pushPc = 1'b1;
                    next_s.irq.internalRestart = 1'b1;
                    next_s.ie = 1'b0;
                    if (ok75) begin
                        next_s.irq.vector = cpu_ctrl_pkg::VEC_R75;
                        next_s.r75Latch = 1'b0;
                        next_s.lastSrc = cpu_ctrl_pkg::SRC_R75;
                    end else if (ok65) begin
                        next_s.irq.vector = cpu_ctrl_pkg::VEC_R65;
                        next_s.lastSrc = cpu_ctrl_pkg::SRC_R65;
                    end else begin
                        next_s.irq.vector = cpu_ctrl_pkg::VEC_R55;
                        next_s.lastSrc = cpu_ctrl_pkg::SRC_R55;
                    end
                end else if (okIntr) begin
                    next_s.irq.take = 1'b1;
                    next_s.irq.vector = cpu_ctrl_pkg::VEC_GENERAL;
                    next_s.irq.pcIncInhibit = 1'b1;
                    next_s.intackPending = 1'b1;
                    next_s.ie = 1'b0;
                    next_s.lastSrc = cpu_ctrl_pkg::SRC_GENERAL_IRQ;
                end
                next_s.lastVector = next_s.irq.vector;
            end

            // a new edge beats a clear in the same cycle, even while masked
            if (edge75) begin
                next_s.r75Latch = 1'b1;
            end
            if (edgeTrap) begin
                next_s.trapLatch = 1'b1;
            end
        end

        // reset wins over the enable and holds for as long as it stays high
        if (reset) begin
            next_s = '0;
            next_s.phase = cpu_ctrl_pkg::PH_IDLE;
            next_s.kind = cpu_ctrl_pkg::KIND_READ;
            next_s.lastSrc = cpu_ctrl_pkg::SRC_NONE;
            next_s.mask = cpu_ctrl_pkg::MASK_RESET;
            next_s.resetActive = 1'b1;
            next_s.ie = 1'b0;
            next_s.bus = '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        s <= next_s;
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign busPins = s.bus;
    assign cycleDone = s.cycleDone;
    assign waitState = s.waitState;
    assign resetActive = s.resetActive;
    assign irqOut = s.irq;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset || !clkEn);

    waitStay_a: assert property (
        (s.phase == cpu_ctrl_pkg::PH_T2 || s.phase == cpu_ctrl_pkg::PH_TW) && !readySync
        |=> s.phase == cpu_ctrl_pkg::PH_TW && !s.cycleDone && s.waitState)
        else $error("cycle finished while ready low");

    waitEnd_a: assert property (
        (s.phase == cpu_ctrl_pkg::PH_T2 || s.phase == cpu_ctrl_pkg::PH_TW) && readySync
        |=> s.phase == cpu_ctrl_pkg::PH_T3 ##1 s.cycleDone)
        else $error("cycle did not finish after ready");

    afterTransfer_a: assert property (
        s.phase == cpu_ctrl_pkg::PH_T3 && holdSync |=> s.bus.grant)
        else $error("grant not given after transfer");

    grantRelease_a: assert property (
        $rose(s.bus.grant) |-> s.bus.driveEn ##1 !s.bus.driveEn)
        else $error("bus not released one cycle after grant");

    grantKept_a: assert property (
        s.bus.grant && holdSync |=> s.bus.grant && !s.bus.driveEn)
        else $error("bus taken back while request high");

    grantFloat_a: assert property (
        s.bus.grant |-> !s.bus.readStrobe && !s.bus.writeStrobe && !s.bus.irqAckStrobe)
        else $error("strobe active while granted");

    busRegain_a: assert property (
        $fell(s.bus.grant) |-> !s.bus.driveEn ##1 s.bus.driveEn)
        else $error("bus not regained one cycle after grant fell");

    ackNotRead_a: assert property (
        s.bus.irqAckStrobe |-> !s.bus.readStrobe && s.intackCycle)
        else $error("acknowledge and read strobe together");

    ieCleared_a: assert property (
        s.irq.take |-> !s.ie)
        else $error("enable still set after acceptance");

    sampleOnly_a: assert property (
        s.irq.take |-> $past(samplePoint))
        else $error("interrupt taken outside a sample point");

    trapFirst_a: assert property (
        s.irq.take && $past(trapOk) |-> s.irq.vector == cpu_ctrl_pkg::VEC_TRAP)
        else $error("trap lost priority");

    restartOverGeneral_a: assert property (
        s.irq.take && $past(ok55) && !$past(trapOk) |-> s.irq.internalRestart)
        else $error("general request beat a restart");

    edgeLatch_a: assert property (
        edge75 |=> s.r75Latch)
        else $error("restart 7.5 edge not latched");

    resetFloat_a: assert property (@(posedge sys_clk) disable iff (1'b0)
        reset |=> !s.bus.driveEn && !s.bus.grant && !s.ie && s.resetActive)
        else $error("outputs not floated in reset");

endmodule : cpu_ctrl

`default_nettype wire

// >>> core/cpu_ctrl_pkg.sv
// constants and types for the processor control-pin block
package cpu_ctrl_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_MASK = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_VECTOR = 8'h0C;

    // field positions
    localparam int IE_BIT = 0;
    localparam int MASK_LSB = 0;
    localparam int MASK_SET_BIT = 3;
    localparam int R75_CLR_BIT = 4;
    localparam int ST_PEND_LSB = 0;
    localparam int ST_IE_BIT = 5;
    localparam int ST_GRANT_BIT = 6;
    localparam int ST_WAIT_BIT = 7;
    localparam int ST_ACKPEND_BIT = 8;
    localparam int VEC_LSB = 0;
    localparam int SRC_LSB = 8;

    // reset values
    localparam logic [2:0] MASK_RESET = 3'h7;

    // restart vectors
    localparam logic [7:0] VEC_TRAP = 8'h24;
    localparam logic [7:0] VEC_R75 = 8'h3C;
    localparam logic [7:0] VEC_R65 = 8'h34;
    localparam logic [7:0] VEC_R55 = 8'h2C;
    localparam logic [7:0] VEC_GENERAL = 8'h00;

    // pin positions in the synchroniser vector
    localparam int PIN_READY = 0;
    localparam int PIN_HOLD = 1;
    localparam int PIN_GENERAL_IRQ = 2;
    localparam int PIN_R55 = 3;
    localparam int PIN_R65 = 4;
    localparam int PIN_R75 = 5;
    localparam int PIN_TRAP = 6;
    localparam int PIN_COUNT = 7;

    typedef enum logic [2:0] {PH_IDLE, PH_T1, PH_T2, PH_TW, PH_T3, PH_GRANT, PH_REGAIN} phase_t;
    typedef enum logic [1:0] {KIND_READ, KIND_WRITE, KIND_FETCH} kind_t;
    typedef enum logic [2:0] {SRC_NONE, SRC_TRAP, SRC_R75, SRC_R65, SRC_R55, SRC_GENERAL_IRQ} src_t;

    typedef struct packed {
        logic start;
        kind_t kind;
    } busReq_t;

    typedef struct packed {
        logic driveEn;
        logic readStrobe;
        logic writeStrobe;
        logic irqAckStrobe;
        logic grant;
    } busPins_t;

    typedef struct packed {
        logic take;
        logic pushPc;
        logic pcIncInhibit;
        logic internalRestart;
        logic [7:0] vector;
    } irqOut_t;

endpackage : cpu_ctrl_pkg

// >>> sim/mem_model.sv
// memory side model: answers bus cycles after a chosen number of waits
`timescale 1ns/10ps
`default_nettype none

module mem_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // bus side
    input wire logic strobe,
    input wire logic [3:0] waitCycles,
    output var logic ready
);
    logic [3:0] cnt;

    always_ff @(posedge sys_clk) begin
        if (reset || !strobe) begin
            cnt <= 4'h0;
        end else if (cnt != 4'hF) begin
            cnt <= cnt + 4'h1;
        end
    end

    // slow device holds ready low until it has counted its own delay
    assign ready = (waitCycles == 4'h0) || (strobe && cnt >= waitCycles);
endmodule : mem_model

`default_nettype wire

// >>> sim/testbench.sv
// self-checking bench for the processor control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin bad_count++; \
    $display("MISMATCH t=%0t got %0h exp %0h", $time, (a), (b)); end end

module testbench;
    typedef struct packed {
        logic [4:0] pins;
        logic ie;
        logic [2:0] mask;
        logic take;
        logic [7:0] vec;
        logic push;
    } row_t;
    logic sys_clk, reset, psel, penable, pwrite, pready, pslverr, ready, err;
    logic busRequest, generalIrq, restart55, restart65, restart75, trapIrq;
    logic nextToLast, cycleDone, waitState, resetActive, wantCycle, clkEn, halted;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [3:0] waitCycles;
    cpu_ctrl_pkg::kind_t kind;
    cpu_ctrl_pkg::busPins_t busPins;
    cpu_ctrl_pkg::busReq_t cycleReq;
    cpu_ctrl_pkg::irqOut_t irqOut, lastOut;
    int bad_count, comparisons, takes, rds, acks, waits, clash, n, t0, r0, a0, w0;
    row_t rows [9];

    // start drops combinationally with done so no second cycle slips in
    assign cycleReq = {wantCycle && !cycleDone, kind};

    cpu_ctrl i_cpu_ctrl (.sys_clk(sys_clk), .reset(reset), .clkEn(clkEn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ready(ready), .busRequest(busRequest), .generalIrq(generalIrq),
        .restart55(restart55), .restart65(restart65), .restart75(restart75),
        .trapIrq(trapIrq), .busPins(busPins), .cycleReq(cycleReq),
        .nextToLast(nextToLast), .halted(halted), .cycleDone(cycleDone),
        .waitState(waitState), .resetActive(resetActive), .irqOut(irqOut));

    mem_model i_mem_model (.sys_clk(sys_clk), .reset(reset),
        .strobe(busPins.readStrobe | busPins.writeStrobe | busPins.irqAckStrobe),
        .waitCycles(waitCycles), .ready(ready));

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        if (irqOut.take === 1'b1) begin
            takes++;
            lastOut = irqOut;
        end
        if (busPins.readStrobe === 1'b1) rds++;
        if (busPins.irqAckStrobe === 1'b1) acks++;
        if (waitState === 1'b1) waits++;
        if (busPins.grant === 1'b1 && (busPins.readStrobe || busPins.writeStrobe)) clash++;
    end

    task wrap_up;
        $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : wrap_up

    task give_up;
        `CHK(1'b0, 1'b1)
        wrap_up;
    endtask : give_up

    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        // pready and data are taken at the rising edge the slave samples
        do begin @(posedge sys_clk); n++; end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) give_up;
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle edge, so a following call never re-raises psel at once
        @(posedge sys_clk);
    endtask : apb

    task cyc(input cpu_ctrl_pkg::kind_t k);
        kind <= k;
        wantCycle <= 1'b1;
        n = 0;
        do begin @(posedge sys_clk); n++; end while (cycleDone !== 1'b1 && n < 40);
        if (cycleDone !== 1'b1) give_up;
        wantCycle <= 1'b0;
    endtask : cyc

    task wait_grant(input logic lvl);
        n = 0;
        do begin @(negedge sys_clk); n++; end while (busPins.grant !== lvl && n < 20);
        if (busPins.grant !== lvl) give_up;
        @(posedge sys_clk);
    endtask : wait_grant

    task do_row(input row_t r);
        apb(1'b1, cpu_ctrl_pkg::OFS_MASK, 32'h18 | {29'h0, r.mask});
        apb(1'b1, cpu_ctrl_pkg::OFS_CTRL, {31'h0, r.ie});
        t0 = takes;
        {trapIrq, restart75, restart65, restart55, generalIrq} <= r.pins;
        repeat (4) @(posedge sys_clk);
        `CHK(takes, t0)
        nextToLast <= 1'b1;
        @(posedge sys_clk);
        nextToLast <= 1'b0;
        repeat (3) @(posedge sys_clk);
        `CHK(takes, t0 + r.take)
        if (r.take) begin
            `CHK(lastOut.vector, r.vec)
            `CHK(lastOut.pushPc, r.push)
            `CHK(lastOut.internalRestart, r.push)
            `CHK(lastOut.pcIncInhibit, !r.push)
            apb(1'b0, cpu_ctrl_pkg::OFS_CTRL, 32'h0);
            `CHK(q[0], 1'b0)
        end
        {trapIrq, restart75, restart65, restart55, generalIrq} <= 5'h0;
        repeat (2) @(posedge sys_clk);
        $display("row %0h done", r.pins);
    endtask : do_row

    initial begin
        rows = '{
            '{5'b10000, 1'b0, 3'h7, 1'b1, 8'h24, 1'b1},
            '{5'b11111, 1'b1, 3'h0, 1'b1, 8'h24, 1'b1},
            '{5'b01111, 1'b1, 3'h0, 1'b1, 8'h3C, 1'b1},
            '{5'b00111, 1'b1, 3'h0, 1'b1, 8'h34, 1'b1},
            '{5'b00011, 1'b1, 3'h0, 1'b1, 8'h2C, 1'b1},
            '{5'b00001, 1'b1, 3'h0, 1'b1, 8'h00, 1'b0},
            '{5'b00010, 1'b1, 3'h7, 1'b0, 8'h00, 1'b0},
            '{5'b00001, 1'b0, 3'h0, 1'b0, 8'h00, 1'b0},
            '{5'b01000, 1'b1, 3'h4, 1'b0, 8'h00, 1'b0}};
        reset = 1'b1;
        clkEn = 1'b1;
        halted = 1'b0;
        {psel, penable, pwrite, busRequest, generalIrq, restart55, restart65} = '0;
        {restart75, trapIrq, nextToLast, wantCycle} = '0;
        paddr = 8'h00;
        pwdata = 32'h0;
        waitCycles = 4'h0;
        kind = cpu_ctrl_pkg::KIND_READ;
        repeat (5) @(posedge sys_clk);
        @(negedge sys_clk);
        `CHK(busPins, 5'h0)
        `CHK(resetActive, 1'b1)
        `CHK(irqOut, 12'h0)
        @(posedge sys_clk);
        reset <= 1'b0;
        apb(1'b0, cpu_ctrl_pkg::OFS_CTRL, 32'h0);
        `CHK(q[0], 1'b0)
        // mask contents after reset are not relied on: write, then read back
        apb(1'b1, cpu_ctrl_pkg::OFS_MASK, 32'h0000_000D);
        apb(1'b0, cpu_ctrl_pkg::OFS_MASK, 32'h0);
        `CHK(q[2:0], 3'h5)
        foreach (rows[i]) do_row(rows[i]);
        // masked 7.5 edge must still be held
        apb(1'b0, cpu_ctrl_pkg::OFS_STATUS, 32'h0);
        `CHK(q[3], 1'b1)
        // halted is a sample point too
        apb(1'b1, cpu_ctrl_pkg::OFS_MASK, 32'h0000_0018);
        apb(1'b1, cpu_ctrl_pkg::OFS_CTRL, 32'h0000_0001);
        t0 = takes;
        restart55 <= 1'b1;
        halted <= 1'b1;
        repeat (5) @(posedge sys_clk);
        `CHK(takes, t0 + 1)
        `CHK(lastOut.vector, 8'h2C)
        restart55 <= 1'b0;
        halted <= 1'b0;
        // a low enable freezes everything, a request included
        clkEn <= 1'b0;
        busRequest <= 1'b1;
        repeat (6) @(posedge sys_clk);
        `CHK(busPins.grant, 1'b0)
        busRequest <= 1'b0;
        clkEn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        $display("sample point and enable tests done");
        r0 = rds;
        cyc(cpu_ctrl_pkg::KIND_READ);
        `CHK(n, 5)
        `CHK(rds - r0, 2)
        @(posedge sys_clk);
        r0 = rds;
        a0 = acks;
        cyc(cpu_ctrl_pkg::KIND_FETCH);
        `CHK(acks - a0, 2)
        `CHK(rds - r0, 0)
        $display("bus cycle tests done");
        // two passes, so a handover also follows a regain
        for (int i = 0; i < 2; i++) begin
            @(posedge sys_clk);
            waitCycles <= 4'h3;
            busRequest <= 1'b1;
            w0 = waits;
            cyc(cpu_ctrl_pkg::KIND_READ);
            `CHK(n > 5, 1'b1)
            `CHK(waits > w0, 1'b1)
            wait_grant(1'b1);
            @(negedge sys_clk);
            `CHK(busPins.driveEn, 1'b0)
            r0 = rds;
            @(posedge sys_clk);
            wantCycle <= 1'b1;
            repeat (6) begin
                @(negedge sys_clk);
                `CHK(busPins.grant, 1'b1)
            end
            @(posedge sys_clk);
            wantCycle <= 1'b0;
            busRequest <= 1'b0;
            `CHK(rds, r0)
            wait_grant(1'b0);
            @(negedge sys_clk);
            `CHK(busPins.driveEn, 1'b1)
        end
        `CHK(clash, 0)
        $display("handover tests done");
        @(posedge sys_clk);
        apb(1'b1, cpu_ctrl_pkg::OFS_CTRL, 32'h1);
        busRequest <= 1'b1;
        wait_grant(1'b1);
        reset <= 1'b1;
        repeat (3) begin
            @(posedge sys_clk);
            @(negedge sys_clk);
            `CHK(busPins, 5'h0)
            `CHK(resetActive, 1'b1)
        end
        @(posedge sys_clk);
        reset <= 1'b0;
        busRequest <= 1'b0;
        @(posedge sys_clk);
        apb(1'b0, cpu_ctrl_pkg::OFS_CTRL, 32'h0);
        `CHK(q[0], 1'b0)
        apb(1'b0, 8'h10, 32'h0);
        `CHK(err, 1'b1)
        `CHK(q, 32'h0)
        $display("reset and decode tests done");
        wrap_up;
    end
endmodule : testbench

`default_nettype wire
